// ==== logic/pst_status_reg.sv ====
// Purpose: PCI function status register with sticky error flags
// Assumes: Configuration access decoded upstream to a 16-bit read/write strobe
// Assumes: Bus event inputs are already synchronous to sys_clk
// Notes: Command-register controls arrive as plain inputs
// Notes: An error event in the clearing cycle keeps its flag set
// Function
// - Set bit 15 on any address or data parity error seen on the bus.
// - Set bit 14 when system error enabled and the function asserted system error.
// - Set bit 13 when a self-initiated cycle ends by master abort.
// - Set bit 12 when a self-initiated cycle is ended by target abort.
// - Set bit 11 when the function, as target, signals target abort.
// - Bits 10 to 9 read constant 01b, medium device-select timing.
// - Set bit 8 on parity error while master with parity response enabled.
// - Bit 7 reads constant 0, no fast back-to-back as target.
// - Bit 6 reads constant 0, no user-definable features.
// - Bit 5 reads constant 1, capable of 66 MHz clock.
// - Bit 4 reads constant 1, capability list with power management exists.
// - Bit 3 shows live interrupt; interrupt line asserts only when not disabled.
// - Interrupt disable masks only the line, never status bit 3.
// - Bits 2 to 0 read zero; writes ignored.
module pst_status_reg
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata_q,
   input wire logic address_parity_error,
   input wire logic data_parity_error,
   input wire logic system_error_enable,
   input wire logic system_error_asserted,
   input wire logic master_abort_received,
   input wire logic target_abort_received,
   input wire logic target_abort_signalled,
   input wire logic parity_error_seen,
   input wire logic bus_master_phase,
   input wire logic parity_response_enable,
   input wire logic interrupt_pending,
   input wire logic interrupt_disable,
   output logic intx_q
);
   // ---------------------------------------------------------------
   // Error events and write-one-to-clear decode
   // ---------------------------------------------------------------
   logic [pst_pkg::NUM_ERR_FLAGS-1:0] set_vec;
   logic [pst_pkg::NUM_ERR_FLAGS-1:0] clr_vec;
   logic [pst_pkg::NUM_ERR_FLAGS-1:0] flag_vec;
   logic status_wr;
   logic status_rd;
   logic [15:0] status_word;
   logic [15:0] cfg_rdata_d;
   logic intx_d;
   logic detected_parity_error_flag;
   logic signalled_system_error_flag;
   logic received_master_abort_flag;
   logic received_target_abort_flag;
   logic signalled_target_abort_flag;
   logic master_data_parity_error_flag;
   logic addr_hit;

   // Positions of the error flags within the flag vectors
   localparam int IDX_PARITY = 5;
   localparam int IDX_SYSTEM_ERROR = 4;
   localparam int IDX_MASTER_ABORT = 3;
   localparam int IDX_TARGET_ABORT_RX = 2;
   localparam int IDX_TARGET_ABORT_TX = 1;
   localparam int IDX_MASTER_PARITY = 0;

   // ---------------------------------------------------------------
   // Configuration access decode
   // ---------------------------------------------------------------
   always_comb
   begin
      addr_hit = 1'b0;
      if (cfg_addr == pst_pkg::STATUS_OFFSET)
      begin
         addr_hit = 1'b1;
      end
   end

   // A write at the status offset wins over a read in the same cycle
   always_comb
   begin
      status_wr = 1'b0;
      status_rd = 1'b0;
      if (cfg_wr && addr_hit)
      begin
         status_wr = 1'b1;
      end
      else if (cfg_rd && addr_hit)
      begin
         status_rd = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Flag set and clear events
   // ---------------------------------------------------------------
   // A level held high sets its flag again on every cycle
   always_comb
   begin
      set_vec = '0;
      if (address_parity_error || data_parity_error)
      begin
         set_vec[IDX_PARITY] = 1'b1;
      end
      if (system_error_enable && system_error_asserted)
      begin
         set_vec[IDX_SYSTEM_ERROR] = 1'b1;
      end
      if (master_abort_received)
      begin
         set_vec[IDX_MASTER_ABORT] = 1'b1;
      end
      if (target_abort_received)
      begin
         set_vec[IDX_TARGET_ABORT_RX] = 1'b1;
      end
      if (target_abort_signalled)
      begin
         set_vec[IDX_TARGET_ABORT_TX] = 1'b1;
      end
      if (parity_error_seen && bus_master_phase && parity_response_enable)
      begin
         set_vec[IDX_MASTER_PARITY] = 1'b1;
      end
   end

   // Write one to clear; a zero leaves the flag alone
   always_comb
   begin
      clr_vec = '0;
      if (status_wr)
      begin
         clr_vec[IDX_PARITY] = cfg_wdata[pst_pkg::BIT_DETECTED_PARITY];
         clr_vec[IDX_SYSTEM_ERROR] = cfg_wdata[pst_pkg::BIT_SIGNALLED_SYSERR];
         clr_vec[IDX_MASTER_ABORT] = cfg_wdata[pst_pkg::BIT_RECEIVED_MASTER_ABORT];
         clr_vec[IDX_TARGET_ABORT_RX] = cfg_wdata[pst_pkg::BIT_RECEIVED_TARGET_ABORT];
         clr_vec[IDX_TARGET_ABORT_TX] = cfg_wdata[pst_pkg::BIT_SIGNALLED_TARGET_ABORT];
         clr_vec[IDX_MASTER_PARITY] = cfg_wdata[pst_pkg::BIT_MASTER_DATA_PARITY];
      end
   end

   // ---------------------------------------------------------------
   // Sticky flags
   // ---------------------------------------------------------------
   // One sticky flag per error bit, a set winning over a clear
   genvar gi;
   generate
      for (gi = 0; gi < pst_pkg::NUM_ERR_FLAGS; gi++)
      begin : g_flag
         pst_sticky_flag u_flag
         (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .set_evt(set_vec[gi]),
            .clr_evt(clr_vec[gi]),
            .flag_q(flag_vec[gi])
         );
      end
   endgenerate

   // Named views of the flag vector
   assign detected_parity_error_flag = flag_vec[IDX_PARITY];
   assign signalled_system_error_flag = flag_vec[IDX_SYSTEM_ERROR];
   assign received_master_abort_flag = flag_vec[IDX_MASTER_ABORT];
   assign received_target_abort_flag = flag_vec[IDX_TARGET_ABORT_RX];
   assign signalled_target_abort_flag = flag_vec[IDX_TARGET_ABORT_TX];
   assign master_data_parity_error_flag = flag_vec[IDX_MASTER_PARITY];

   // ---------------------------------------------------------------
   // Status word and read data
   // ---------------------------------------------------------------
   // Constant fields are wired here; only the flags and bit 3 move
   always_comb
   begin
      status_word = 16'h0000;
      status_word[pst_pkg::BIT_DETECTED_PARITY] = detected_parity_error_flag;
      status_word[pst_pkg::BIT_SIGNALLED_SYSERR] = signalled_system_error_flag;
      status_word[pst_pkg::BIT_RECEIVED_MASTER_ABORT] = received_master_abort_flag;
      status_word[pst_pkg::BIT_RECEIVED_TARGET_ABORT] = received_target_abort_flag;
      status_word[pst_pkg::BIT_SIGNALLED_TARGET_ABORT] = signalled_target_abort_flag;
      status_word[pst_pkg::BIT_DEVSEL_HI:pst_pkg::BIT_DEVSEL_LO] = pst_pkg::DEVSEL_MEDIUM;
      status_word[pst_pkg::BIT_MASTER_DATA_PARITY] = master_data_parity_error_flag;
      status_word[pst_pkg::BIT_FAST_B2B] = pst_pkg::FAST_B2B_VALUE;
      status_word[pst_pkg::BIT_USER_FEATURES] = pst_pkg::USER_FEATURES_VALUE;
      status_word[pst_pkg::BIT_HIGH_SPEED] = pst_pkg::HIGH_SPEED_VALUE;
      status_word[pst_pkg::BIT_CAP_LIST] = pst_pkg::CAP_LIST_VALUE;
      status_word[pst_pkg::BIT_INT_STATUS] = interrupt_pending;
      status_word[2:0] = pst_pkg::RESERVED_LOW;
   end

   // Read data stand for one cycle only; any other cycle returns zero
   always_comb
   begin
      cfg_rdata_d = 16'h0000;
      if (rst_n && status_rd)
      begin
         cfg_rdata_d = status_word;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      cfg_rdata_q <= cfg_rdata_d;
   end

   // ---------------------------------------------------------------
   // Interrupt line
   // ---------------------------------------------------------------
   // Disable masks only the line; bit 3 keeps showing the pending state
   always_comb
   begin
      intx_d = 1'b0;
      if (rst_n && !interrupt_disable)
      begin
         intx_d = interrupt_pending;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      intx_q <= intx_d;
   end
endmodule

// ==== logic/pst_pkg.sv ====
// Purpose: Constants for the PCI function status register block
// Assumes: 16-bit status word at configuration offset 0x06
// Notes: Field positions are used by the design; the bench uses only STATUS_OFFSET; STATUS_RESET is unused
package pst_pkg;
   localparam logic [7:0] STATUS_OFFSET = 8'h06;
   localparam logic [15:0] STATUS_RESET = 16'h0230;
   localparam int BIT_DETECTED_PARITY = 15;
   localparam int BIT_SIGNALLED_SYSERR = 14;
   localparam int BIT_RECEIVED_MASTER_ABORT = 13;
   localparam int BIT_RECEIVED_TARGET_ABORT = 12;
   localparam int BIT_SIGNALLED_TARGET_ABORT = 11;
   localparam int BIT_DEVSEL_HI = 10;
   localparam int BIT_DEVSEL_LO = 9;
   localparam int BIT_MASTER_DATA_PARITY = 8;
   localparam int BIT_FAST_B2B = 7;
   localparam int BIT_USER_FEATURES = 6;
   localparam int BIT_HIGH_SPEED = 5;
   localparam int BIT_CAP_LIST = 4;
   localparam int BIT_INT_STATUS = 3;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic FAST_B2B_VALUE = 1'h0;
   localparam logic USER_FEATURES_VALUE = 1'h0;
   localparam logic HIGH_SPEED_VALUE = 1'h1;
   localparam logic CAP_LIST_VALUE = 1'h1;
   localparam logic [2:0] RESERVED_LOW = 3'h0;
   localparam int NUM_ERR_FLAGS = 6;
endpackage

// ==== logic/pst_sticky_flag.sv ====
// Purpose: One write-one-to-clear sticky error flag
// Assumes: Synchronous active-low reset
// Notes: A set in the clearing cycle wins over the clear
module pst_sticky_flag
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic set_evt,
   input wire logic clr_evt,
   output logic flag_q
);
   logic flag_d;

   always_comb
   begin
      flag_d = flag_q;
      if (set_evt)
      begin
         flag_d = 1'b1;
      end
      else if (clr_evt)
      begin
         flag_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         flag_q <= 1'b0;
      end
      else
      begin
         flag_q <= flag_d;
      end
   end
endmodule

// ==== dv/pst_status_properties.sv ====
// Purpose: Port properties of the status register
// Assumes: Synchronous active-low reset
// Notes: Bound from tb_top
module pst_status_props
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   input wire logic [15:0] cfg_rdata_q,
   input wire logic address_parity_error,
   input wire logic data_parity_error,
   input wire logic master_abort_received,
   input wire logic parity_error_seen,
   input wire logic bus_master_phase,
   input wire logic parity_response_enable,
   input wire logic interrupt_pending,
   input wire logic interrupt_disable,
   input wire logic intx_q
);
   logic rd;
   logic wr;
   logic pe;
   assign rd = cfg_rd && !cfg_wr && cfg_addr == pst_pkg::STATUS_OFFSET;
   assign wr = cfg_wr && cfg_addr == pst_pkg::STATUS_OFFSET;
   assign pe = address_parity_error || data_parity_error;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   a_fixed_bits: assert property (
      rd |=> cfg_rdata_q[10:9] == 2'h1 && cfg_rdata_q[7:4] == 4'h3 && cfg_rdata_q[2:0] == 3'h0)
      else $error("fixed bits wrong");
   a_int_live: assert property (
      rd |=> cfg_rdata_q[3] == $past(interrupt_pending)) else $error("bit3 wrong");
   a_intx_mask: assert property (
      $past(rst_n) |-> intx_q == ($past(interrupt_pending) && !$past(interrupt_disable)))
      else $error("intx wrong");
   a_parity_sets: assert property (
      pe ##1 rd |=> cfg_rdata_q[15]) else $error("bit15 not set");
   a_abort_sets: assert property (
      master_abort_received ##1 rd |=> cfg_rdata_q[13]) else $error("bit13 not set");
   a_mdpe_sets: assert property (
      parity_error_seen && bus_master_phase && parity_response_enable ##1 rd |=> cfg_rdata_q[8])
      else $error("bit8 not set");
   a_w1c_clears: assert property (
      wr && cfg_wdata[15] && !pe ##1 rd |=> !cfg_rdata_q[15]) else $error("bit15 kept");
   a_idle_zero: assert property (
      !rd |=> cfg_rdata_q == 16'h0) else $error("idle data not zero");
endmodule

// ==== dv/pst_pci_agent.sv ====
// Purpose: Far-side agents raising bus events
// Assumes: Events are bench requests registered for one cycle; a request can repeat on consecutive cycles
// Notes: Density chosen by the bench
module pst_pci_agent
(
   input wire logic sys_clk,
   input wire logic [6:0] req,
   output logic [6:0] ev_q
);
   logic [6:0] ev_d;
   always_comb ev_d = req;
   always_ff @(posedge sys_clk) ev_q <= ev_d;
endmodule

// ==== dv/tb_top.sv ====
// Purpose: Random self-checking bench for the status register
// Assumes: Bench model of flags built from the bit rules
// Notes: Read data and interrupt line compared every cycle
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, rst_n = 0, cfg_rd = 0, cfg_wr = 0, go = 0, intx_q, exp_ix = 0;
   logic [7:0] cfg_addr = 8'h0;
   logic [15:0] cfg_wdata = 16'h0, cfg_rdata_q, f = 16'h0, exp_rd = 16'h0;
   logic [4:0] lv = 5'h0;
   logic [6:0] req = 7'h0, ev;
   logic [31:0] r = 32'h3;
   int failures = 0, n_checks = 0;
   always #25 sys_clk = ~sys_clk;
   pst_pci_agent agent_u (.sys_clk(sys_clk), .req(req), .ev_q(ev));
   pst_status_reg dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
      .address_parity_error(ev[0]), .data_parity_error(ev[1]), .system_error_enable(lv[0]),
      .system_error_asserted(ev[2]), .master_abort_received(ev[3]),
      .target_abort_received(ev[4]), .target_abort_signalled(ev[5]),
      .parity_error_seen(ev[6]), .bus_master_phase(lv[1]), .parity_response_enable(lv[2]),
      .interrupt_pending(lv[3]), .interrupt_disable(lv[4]), .intx_q(intx_q));
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   always @(posedge sys_clk)
   begin
      go <= 1'h1;
      exp_rd = 16'h0;
      if (!rst_n)
         f = 16'h0;
      else
      begin
         if (cfg_rd && !cfg_wr && cfg_addr == 8'h06)
            exp_rd = f | 16'h0230 | {12'h0, lv[3], 3'h0};
         if (cfg_wr && cfg_addr == 8'h06)
            f = f & ~(cfg_wdata & 16'hf900);
         f = f | {ev[0] | ev[1], ev[2] & lv[0], ev[3], ev[4], ev[5], 2'h0,
            ev[6] & lv[1] & lv[2], 8'h0};
      end
      exp_ix = rst_n && lv[3] && !lv[4];
      r = xs(r);
      req <= r[6:0] & r[13:7] & r[20:14];
      lv <= r[25:21];
      cfg_rd <= rst_n & r[26];
      cfg_wr <= rst_n & r[27];
      cfg_addr <= r[28] ? 8'h06 : {4'h0, r[31:28]};
      cfg_wdata <= r[15:0];
   end
   always @(negedge sys_clk)
      if (go)
      begin
         `CHK(cfg_rdata_q, exp_rd)
         `CHK(intx_q, exp_ix)
      end
   task conclude;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'h1;
      repeat (3000) @(posedge sys_clk);
      rst_n <= 1'h0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'h1;
      repeat (1000) @(posedge sys_clk);
      conclude;
   end
endmodule
bind pst_status_reg pst_status_props chk_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_rd(cfg_rd),
   .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
   .address_parity_error(address_parity_error), .data_parity_error(data_parity_error),
   .master_abort_received(master_abort_received), .parity_error_seen(parity_error_seen),
   .bus_master_phase(bus_master_phase), .parity_response_enable(parity_response_enable),
   .interrupt_pending(interrupt_pending), .interrupt_disable(interrupt_disable),
   .intx_q(intx_q));
